// ===== rtl/config_crc_error_detect.sv
// Configuration integrity checker: CRC over memory, stored reference, readout.
// Assumes host scan strobes and readout clock arrive from outside the clock
// domain and are synchronised here; memory writes come from same-clock logic.
`timescale 1ns/1ps
module config_crc_error_detect #(
  parameter int AW = crc_check_pkg::MEM_AW_DEFAULT
) (
  // Clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       nrst,
  // Check configuration and status
  input  wire logic [8:0]                 check_divisor,
  input  wire logic                       user_mode,
  output logic                            fault_pin,
  output logic                            fault_core,
  output logic [31:0]                     signature,
  // Configuration memory write port
  input  wire logic                       mem_wr_en,
  input  wire logic [AW-1:0]              mem_wr_addr,
  input  wire logic [31:0]                mem_wr_data,
  // Host reference scan port
  input  wire crc_check_pkg::scan_ctl_t   scan_in,
  output logic                            scan_tdo,
  // Core readout port
  input  wire logic                       readout_clock,
  input  wire crc_check_pkg::readout_ctl_t readout_ctl,
  output logic                            readout_serial
);

  // ---------------------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------------------
  localparam int NSYNC = 8;   // Readout clock, two readout controls, five scan bits
  logic [NSYNC-1:0] sync_a;
  logic [NSYNC-1:0] sync_b;
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] synced;
  logic             rclk_prev;

  // Gather every outside input into one vector
  assign raw_in = {readout_clock, readout_ctl, scan_in};
  assign synced = sync_b;

  // Two-stage synchroniser for every outside input
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= raw_in;
      sync_b <= sync_a;
    end
  end

  crc_check_pkg::scan_ctl_t    scan;
  crc_check_pkg::readout_ctl_t rctl;
  logic                        rclk_s;
  logic                        scan_prev_cap;
  logic                        scan_prev_sh;
  logic                        scan_prev_up;
  logic                        rclk_rise;
  logic                        cap_rise;
  logic                        sh_rise;
  logic                        up_rise;

  // Unpack synchronised inputs and detect their rising edges
  assign scan      = synced[4:0];
  assign rctl      = synced[6:5];
  assign rclk_s    = synced[NSYNC-1];
  assign rclk_rise = rclk_s & ~rclk_prev;
  assign cap_rise  = scan.capture & ~scan_prev_cap;
  assign sh_rise   = scan.shift & ~scan_prev_sh;
  assign up_rise   = scan.update & ~scan_prev_up;

  // ---------------------------------------------------------------------------
  // Check tick and memory scan
  // ---------------------------------------------------------------------------
  logic          tick;
  logic [AW-1:0] rd_addr;
  logic [31:0]   rd_data;

  check_clock_div u_div (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .divisor (check_divisor),
    .tick    (tick)
  );

  config_mem #(.AW(AW)) u_mem (
    .clk_sys (clk_sys),
    .wr_en   (mem_wr_en),
    .wr_addr (mem_wr_addr),
    .wr_data (mem_wr_data),
    .rd_addr (rd_addr),
    .rd_data (rd_data)
  );

  // One CRC word step, bit serial MSB first
  function automatic logic [31:0] crc_word(input logic [31:0] c, input logic [31:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 31; i >= 0; i--) begin
      r = {r[30:0], 1'b0} ^ ((r[31] ^ d[i]) ? crc_check_pkg::CRC_POLY : 32'h00000000);
    end
    return r;
  endfunction

  // ---------------------------------------------------------------------------
  // Checker state: address walk, running CRC, signature, reference, fault
  // ---------------------------------------------------------------------------
  logic [AW-1:0] next_rd_addr;
  logic [31:0]   crc_acc;
  logic [31:0]   next_crc_acc;
  logic [31:0]   next_signature;
  logic          data_valid;
  logic          next_data_valid;
  logic          last_word;
  logic          next_last_word;
  logic [31:0]   reference;
  logic [31:0]   next_reference;
  logic [31:0]   scan_sr;
  logic [31:0]   next_scan_sr;
  logic          next_fault;
  logic          sig_valid;
  logic          next_sig_valid;

  // Walk memory one word per check tick and fold into the CRC
  always_comb begin
    next_rd_addr    = rd_addr;
    next_crc_acc    = crc_acc;
    next_signature  = signature;
    next_data_valid = tick;
    next_last_word  = last_word;
    next_sig_valid  = sig_valid;
    if (tick) begin
      next_rd_addr   = rd_addr + {{(AW-1){1'b0}}, 1'b1};
      next_last_word = (rd_addr == {AW{1'b1}});
    end
    if (data_valid) begin
      if (last_word) begin
        next_signature = crc_word(crc_acc, rd_data);
        next_crc_acc   = crc_check_pkg::CRC_SEED;
        next_sig_valid = 1'b1;
      end else begin
        next_crc_acc = crc_word(crc_acc, rd_data);
      end
    end
  end

  // Host scan path on the reference store, honoured only in user mode
  always_comb begin
    next_scan_sr   = scan_sr;
    next_reference = reference;
    if (user_mode && scan.sel) begin
      if (cap_rise) begin
        next_scan_sr = reference;
      end else if (sh_rise) begin
        next_scan_sr = {scan.tdi, scan_sr[31:1]};
      end else if (up_rise) begin
        next_reference = scan_sr;
      end
    end
  end

  // Fault follows comparison; clears when reference restored
  always_comb begin
    next_fault = sig_valid && (signature != reference);
  end

  // Register checker, scan and fault state
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      rd_addr       <= '0;
      crc_acc       <= crc_check_pkg::CRC_SEED;
      signature     <= crc_check_pkg::SHIFT_RESET;
      data_valid    <= 1'b0;
      last_word     <= 1'b0;
      sig_valid     <= 1'b0;
      reference     <= crc_check_pkg::REF_RESET;
      scan_sr       <= crc_check_pkg::REF_RESET;
      scan_prev_cap <= 1'b0;
      scan_prev_sh  <= 1'b0;
      scan_prev_up  <= 1'b0;
      scan_tdo      <= 1'b0;
      fault_pin     <= 1'b0;
      fault_core    <= 1'b0;
    end else begin
      rd_addr       <= next_rd_addr;
      crc_acc       <= next_crc_acc;
      signature     <= next_signature;
      data_valid    <= next_data_valid;
      last_word     <= next_last_word;
      sig_valid     <= next_sig_valid;
      reference     <= next_reference;
      scan_sr       <= next_scan_sr;
      scan_prev_cap <= scan.capture;
      scan_prev_sh  <= scan.shift;
      scan_prev_up  <= scan.update;
      scan_tdo      <= next_scan_sr[0];
      fault_pin     <= next_fault;
      fault_core    <= next_fault;
    end
  end

  // ---------------------------------------------------------------------------
  // Readout shift register, acts on synchronised readout clock rise
  // ---------------------------------------------------------------------------
  logic [31:0] readout_sr;
  logic [31:0] next_readout_sr;
  logic        next_readout_serial;

  always_comb begin
    next_readout_sr = readout_sr;
    if (rclk_rise) begin
      if (rctl.shift_not_load) begin
        next_readout_sr = {1'b0, readout_sr[31:1]};
      end else if (rctl.load_source) begin
        next_readout_sr = signature;
      end else begin
        next_readout_sr = reference;
      end
    end
    next_readout_serial = ~next_readout_sr[0];
  end

  // Register readout state and edge detector
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      readout_sr     <= crc_check_pkg::SHIFT_RESET;
      readout_serial <= 1'b1;
      rclk_prev      <= 1'b0;
    end else begin
      readout_sr     <= next_readout_sr;
      readout_serial <= next_readout_serial;
      rclk_prev      <= rclk_s;
    end
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  // Fault flag against the comparison, signature held within a pass
  a_fault_follows: assert property (@(posedge clk_sys) disable iff (!nrst)
    (sig_valid && signature != reference) |=> fault_pin)
    else $error("fault pin not raised on mismatch");
  a_fault_clears: assert property (@(posedge clk_sys) disable iff (!nrst)
    (sig_valid && signature == reference) |=> !fault_pin)
    else $error("fault pin not cleared on match");
  a_core_matches: assert property (@(posedge clk_sys) disable iff (!nrst)
    fault_core == fault_pin)
    else $error("core flag and pin disagree");
  a_sig_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
    !(data_valid && last_word) |=> $stable(signature))
    else $error("signature moved inside a pass");

  // Host scan path on the reference store
  a_no_write_out: assert property (@(posedge clk_sys) disable iff (!nrst)
    !user_mode |=> reference == $past(reference))
    else $error("reference changed outside user mode");
  a_capture_old: assert property (@(posedge clk_sys) disable iff (!nrst)
    (user_mode && scan.sel && cap_rise) |=> scan_sr == $past(reference))
    else $error("capture did not take old reference");
  a_shift_in: assert property (@(posedge clk_sys) disable iff (!nrst)
    (user_mode && scan.sel && !cap_rise && sh_rise) |=> scan_sr == {$past(scan.tdi), $past(scan_sr[31:1])})
    else $error("scan shift step wrong");
  a_ref_update: assert property (@(posedge clk_sys) disable iff (!nrst)
    (user_mode && scan.sel && !cap_rise && !sh_rise && up_rise) |=> reference == $past(scan_sr))
    else $error("reference not updated from scan");
  a_tdo_lsb: assert property (@(posedge clk_sys) disable iff (!nrst)
    scan_tdo == scan_sr[0])
    else $error("scan output not the shift register lsb");

  // Readout shift register
  a_load_sig: assert property (@(posedge clk_sys) disable iff (!nrst)
    (rclk_rise && !rctl.shift_not_load && rctl.load_source) |=> readout_serial == ~$past(signature[0]))
    else $error("signature load wrong");
  a_load_ref: assert property (@(posedge clk_sys) disable iff (!nrst)
    (rclk_rise && !rctl.shift_not_load && !rctl.load_source) |=> readout_sr == $past(reference))
    else $error("reference load wrong");
  a_shift_step: assert property (@(posedge clk_sys) disable iff (!nrst)
    (rclk_rise && rctl.shift_not_load) |=> readout_sr == {1'b0, $past(readout_sr[31:1])})
    else $error("shift step wrong");
  a_hold_idle: assert property (@(posedge clk_sys) disable iff (!nrst)
    !rclk_rise |=> $stable(readout_sr))
    else $error("readout moved without clock");
  a_out_inverted: assert property (@(posedge clk_sys) disable iff (!nrst)
    readout_serial == ~readout_sr[0])
    else $error("serial output not inverted");

endmodule

// ===== rtl/crc_check_pkg.sv
// Shared constants and carrier types for the configuration integrity checker.
// Assumes a single system clock; rtl/ modules use all values here except SIG_W and DIV_RESET.
package crc_check_pkg;

  // ---------------------------------------------------------------------------
  // Widths and counts
  // ---------------------------------------------------------------------------
  localparam int          SIG_W          = 32;
  localparam logic [31:0] CRC_POLY       = 32'h04c11db7;
  localparam logic [31:0] CRC_SEED       = 32'hffffffff;
  localparam logic [8:0]  DIV_MIN        = 9'h001;
  localparam logic [8:0]  DIV_MAX        = 9'h100;
  localparam logic [8:0]  DIV_RESET      = 9'h001;
  localparam logic [31:0] REF_RESET      = 32'h00000000;
  localparam logic [31:0] SHIFT_RESET    = 32'h00000000;
  localparam int          MEM_AW_DEFAULT = 6;

  // Readout control group, sampled on the readout clock edge
  typedef struct packed {
    logic shift_not_load;
    logic load_source;
  } readout_ctl_t;

  // Host scan port towards the reference store
  typedef struct packed {
    logic        sel;
    logic        capture;
    logic        shift;
    logic        update;
    logic        tdi;
  } scan_ctl_t;

endpackage

// ===== rtl/config_mem.sv
// Small configuration memory image scanned word by word by the checker.
// Assumes a single clock; read data come from a register one cycle late.
`timescale 1ns/1ps
module config_mem #(
  parameter int AW = 6
) (
  // Clock only
  input  wire logic          clk_sys,
  // Write port
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [31:0]   wr_data,
  // Read port
  input  wire logic [AW-1:0] rd_addr,
  output logic      [31:0]   rd_data
);

  logic [31:0] mem [0:(1<<AW)-1];

  // Registered read, plain write
  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule

// ===== rtl/check_clock_div.sv
// Divides the system clock into a one-cycle check tick, divisor 1 to 256.
// Assumes divisor is a same-clock level; out-of-range values are clamped.
`timescale 1ns/1ps
module check_clock_div (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  // Divisor and tick
  input  wire logic [8:0] divisor,
  output logic            tick
);

  logic [8:0] count;
  logic [8:0] next_count;
  logic [8:0] lim;
  logic       next_tick;

  // Clamp divisor and count up to the tick
  always_comb begin
    lim = divisor;
    if (divisor < crc_check_pkg::DIV_MIN) begin
      lim = crc_check_pkg::DIV_MIN;
    end else if (divisor > crc_check_pkg::DIV_MAX) begin
      lim = crc_check_pkg::DIV_MAX;
    end
    next_tick  = 1'b0;
    next_count = count + 9'h001;
    if (count + 9'h001 >= lim) begin
      next_count = 9'h000;
      next_tick  = 1'b1;
    end
  end

  // Register counter and tick
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      count <= 9'h000;
      tick  <= 1'b0;
    end else begin
      count <= next_count;
      tick  <= next_tick;
    end
  end

endmodule

// ===== sim/far_side_model.sv
// Far-side model: core reader of the readout register and the scan host.
// Assumes the bench calls its tasks; every drive lands on a falling edge.
`timescale 1ns/1ps
module far_side_model (
  // Clock
  input  wire logic                   clk_sys,
  // Readout side
  output crc_check_pkg::readout_ctl_t readout_ctl,
  output logic                        readout_clock,
  input  wire logic                   readout_serial,
  // Host scan side
  output crc_check_pkg::scan_ctl_t    scan_in,
  input  wire logic                   scan_tdo
);
  // Idle levels, readout clock stands still between words
  initial begin
    readout_ctl   = '0;
    readout_clock = 1'b0;
    scan_in       = '0;
  end

  // Wait some falling edges
  task automatic idle(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  // One readout clock, four cycles high and four low
  task automatic rclk();
    readout_clock = 1'b1;
    idle(4);
    readout_clock = 1'b0;
    idle(4);
  endtask

  // One scan strobe on a bit of the scan struct
  task automatic strobe(input int b);
    scan_in[b] = 1'b1;
    idle(4);
    scan_in[b] = 1'b0;
    idle(4);
  endtask

  // Load then 31 shifts, each bit inverted back, source randomised meanwhile
  task automatic read_word(input logic src, output logic [31:0] val);
    readout_ctl = '{1'b0, src};
    rclk();
    for (int i = 0; i < 32; i++) begin
      val[i] = ~readout_serial;
      readout_ctl = '{1'b1, 1'($urandom)};
      if (i < 31) rclk();
    end
  endtask

  // Capture old reference, shift in new one LSB first, then update
  task automatic write_ref(input logic [31:0] nv, output logic [31:0] ov);
    scan_in.sel = 1'b1;
    strobe(3);
    for (int i = 0; i < 32; i++) begin
      ov[i] = scan_tdo;
      scan_in.tdi = nv[i];
      strobe(2);
    end
    strobe(1);
    scan_in.sel = 1'b0;
  endtask
endmodule

// ===== sim/config_crc_error_detect_tb_top.sv
// Bench top: random memory image, reference injection and readout checks.
// Assumes far_side_model drives the scan and readout ports of the checker.
`timescale 1ns/1ps
module config_crc_error_detect_tb_top;
  localparam int AW = 4;
  logic                        clk_sys, nrst, user_mode, mem_wr_en;
  logic                        fault_pin, fault_core, scan_tdo;
  logic                        readout_clock, readout_serial;
  logic [8:0]                  check_divisor;
  logic [AW-1:0]               mem_wr_addr;
  logic [31:0]                 mem_wr_data, signature, got, old, good, bad;
  logic [31:0]                 img [2**AW];
  crc_check_pkg::scan_ctl_t    scan_in;
  crc_check_pkg::readout_ctl_t readout_ctl;
  int                          fails = 0;
  int                          checks = 0;
  int                          cycles = 0;

  config_crc_error_detect #(.AW(AW)) dut (.clk_sys(clk_sys), .nrst(nrst),
    .check_divisor(check_divisor), .user_mode(user_mode), .fault_pin(fault_pin),
    .fault_core(fault_core), .signature(signature), .mem_wr_en(mem_wr_en),
    .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data), .scan_in(scan_in),
    .scan_tdo(scan_tdo), .readout_clock(readout_clock), .readout_ctl(readout_ctl),
    .readout_serial(readout_serial));
  far_side_model u_far (.clk_sys(clk_sys), .readout_ctl(readout_ctl),
    .readout_clock(readout_clock), .readout_serial(readout_serial),
    .scan_in(scan_in), .scan_tdo(scan_tdo));

  // ---------------------------------------------------------------------------
  // Clock, timeout and helpers
  // ---------------------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // Cut a hang short
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      fails = fails + 1;
      print_verdict();
    end
  end

  // Signature of the image, seeded, MSB first, word 0 first
  function automatic logic [31:0] crc_of();
    logic [31:0] c;
    c = crc_check_pkg::CRC_SEED;
    for (int w = 0; w < 2**AW; w++)
      for (int b = 31; b >= 0; b--)
        c = {c[30:0], 1'b0} ^ ((c[31] ^ img[w][b]) ? crc_check_pkg::CRC_POLY : 32'h0);
    return c;
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks = checks + 1;
    if (g !== e) begin
      fails = fails + 1;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Let n full memory passes go by
  task automatic passes(input int n);
    repeat (n * (2**AW) * check_divisor + 30) @(negedge clk_sys);
  endtask

  task automatic mwr(input int a, input logic [31:0] d);
    mem_wr_addr = a[AW-1:0];
    mem_wr_data = d;
    mem_wr_en   = 1'b1;
    @(negedge clk_sys);
  endtask

  task automatic print_verdict();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    void'($urandom(88));
    nrst          = 1'b0;
    user_mode     = 1'b1;
    mem_wr_en     = 1'b0;
    mem_wr_addr   = '0;
    mem_wr_data   = '0;
    check_divisor = 9'h001 + 9'($urandom % 8);
    repeat (2) @(negedge clk_sys);
    chk({29'h0, fault_pin, fault_core, readout_serial}, 32'h1);
    nrst = 1'b1;
    for (int w = 0; w < 2**AW; w++) begin
      img[w] = $urandom;
      mwr(w, img[w]);
    end
    mem_wr_en = 1'b0;
    good = crc_of();
    bad  = good ^ (32'h1 << ($urandom % 32));
    passes(2);
    chk({30'h0, fault_pin, fault_core}, 32'h3);
    chk(signature, good);
    u_far.read_word(1'b1, got);
    chk(got, good);
    u_far.write_ref(good, old);
    chk(old, crc_check_pkg::REF_RESET);
    passes(2);
    chk({30'h0, fault_pin, fault_core}, 32'h0);
    u_far.read_word(1'b0, got);
    chk(got, good);
    // Inject a wrong reference, then restore it
    u_far.write_ref(bad, old);
    chk(old, good);
    passes(2);
    chk({30'h0, fault_pin, fault_core}, 32'h3);
    u_far.write_ref(old, got);
    chk(got, bad);
    passes(2);
    chk({30'h0, fault_pin, fault_core}, 32'h0);
    // Scan outside user mode is refused
    user_mode = 1'b0;
    u_far.write_ref(~good, got);
    user_mode = 1'b1;
    passes(2);
    chk({31'h0, fault_pin}, 32'h0);
    u_far.read_word(1'b0, got);
    chk(got, good);
    // Memory upset at the largest divisor, then repair
    check_divisor = 9'h100;
    img[3] = img[3] ^ 32'h00000100;
    mwr(3, img[3]);
    mem_wr_en = 1'b0;
    passes(2);
    chk({30'h0, fault_pin, fault_core}, 32'h3);
    chk(signature, crc_of());
    check_divisor = 9'h002;
    img[3] = img[3] ^ 32'h00000100;
    mwr(3, img[3]);
    mem_wr_en = 1'b0;
    passes(3);
    chk({30'h0, fault_pin, fault_core}, 32'h0);
    u_far.read_word(1'b1, got);
    chk(got, good);
    print_verdict();
  end
endmodule
